//--- include/hims_cfg.svh
`ifndef HIMS_CFG_SVH
`define HIMS_CFG_SVH

// System clock rate in kHz
`define SYS_CLK_KHZ 20000
// Typical sensor drive pulse rate in kHz
`define DRIVE_FREQ_KHZ 143
// Half period of the drive pulse in system clock cycles, rounded down
`define DRIVE_HALF_CYCLES ((`SYS_CLK_KHZ) / (2 * `DRIVE_FREQ_KHZ))
// Width of the drive divider counter
`define DRIVE_CNT_BITS 8
// Base of the 7-bit slave address
`define SLAVE_ADDR_BASE 7'h16
// Number of sense channels
`define NUM_SENSE 16
// Width of a measurement result
`define RESULT_BITS 8
// Bits in one serial byte
`define SPI_BITS 8
// Interrupt line level while in reset
`define IRQ_RESET_LEVEL 1'b1

`endif

//--- include/hims_pkg.sv
package hims_pkg;

  // Raw pins that cross into the system clock domain
  typedef struct packed {
    logic extRstLow;
    logic select;
    logic dataLevel;
    logic addr0;
    logic addr1;
    logic clkLevel;
  } pin_sync_t;

  // Host interface mode
  typedef enum logic {
    MODE_I2C,
    MODE_SPI
  } mode_t;

  // One measurement result
  typedef struct packed {
    logic [3:0] channel;
    logic [7:0] value;
  } result_t;

endpackage

//--- rtl/host_interface_mode_select.sv
`timescale 1ns/1ps
`include "hims_cfg.svh"

// Overview of operation
// - Start in I2C slave mode after initialization.
// - Select high-to-low switches to SPI, chip select.
// - SPI mode latched until next reset.
// - External reset low holds all logic initial except the synchronisers and link shifter.
// - Sense and reference pins high impedance in reset.
// - Unselected sense channels driven low while measuring.
// - Interrupt output is active high.
// - Clock pin serves I2C or SPI clock.
// - Data pin open-drain I2C, SPI input only.
// - Address pin is address bit or SPI out.
// - Drive pin outputs pulse waveform while measuring.
// - Each channel result is an 8-bit value.
// - Slave address is base plus address inputs.
// - Interrupt falls high-to-low at reset release.
module host_interface_mode_select import hims_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic externalResetLow,
  input wire logic interfaceSelectStrobe,
  input wire logic dataPinIn,
  output logic dataPinOut,
  output logic dataPinOe,
  input wire logic addressSelect0OrDataOutIn,
  output logic addressSelect0OrDataOutOut,
  output logic addressSelect0OrDataOutOe,
  input wire logic addressSelect1,
  output logic [`NUM_SENSE-1:0] senseInputsOut,
  output logic [`NUM_SENSE-1:0] senseInputsOe,
  output logic refOut,
  output logic refOe,
  output logic extraReferenceInputOut,
  output logic extraReferenceInputOe,
  output logic sensorDrive,
  output logic interruptLine,
  input wire logic i2cDataPullLow,
  input wire logic measureActive,
  input wire logic [3:0] measureChannel,
  input wire logic measureValid,
  input wire logic [`RESULT_BITS-1:0] measureValue,
  input wire logic interruptRequest,
  input wire logic [`SPI_BITS-1:0] spiTxByte,
  output logic spiMode,
  output logic inReset,
  output logic [6:0] slaveAddress,
  output logic i2cClockLevel,
  output logic i2cDataLevel,
  output logic [`RESULT_BITS-1:0] resultValue,
  output logic [3:0] resultChannel,
  output logic resultReady,
  output logic [`SPI_BITS-1:0] spiRxByte,
  output logic spiRxValid
);

  // Pin synchronisers, first and second stage
  pin_sync_t pinMeta;
  pin_sync_t pinSync;
  pin_sync_t pinRaw;

  // Mode state and select edge detection
  mode_t mode;
  logic selectPrev; // Last synced select level

  // Reset state
  logic resetHold; // Core held in initial state

  // Sensor drive divider
  logic [`DRIVE_CNT_BITS-1:0] driveCount;

  // Link hand-over
  logic [`SPI_BITS-1:0] txHold; // Byte offered to the link
  logic [`SPI_BITS-1:0] linkRxByte; // Byte from link domain
  logic linkRxToggle; // Link byte event
  logic toggleMeta; // First stage of toggle crossing
  logic toggleSync; // Second stage
  logic toggleSeen; // Last handled toggle
  logic linkSerialOut; // Data out from link domain
  logic frameIdle; // Chip select inactive

  // Drive divider limit sized to the counter
  localparam logic [`DRIVE_CNT_BITS-1:0] DRIVE_LAST =
    `DRIVE_CNT_BITS'(`DRIVE_HALF_CYCLES - 1);

  // Address from the two select inputs
  function automatic logic [6:0] addrOf(input logic hi, input logic lo);
    addrOf = `SLAVE_ADDR_BASE + {5'h00, hi, lo};
  endfunction

  // Gather raw pins into one carrier
  always_comb begin
    pinRaw.extRstLow = externalResetLow;
    pinRaw.select = interfaceSelectStrobe;
    pinRaw.dataLevel = dataPinIn;
    pinRaw.addr0 = addressSelect0OrDataOutIn;
    pinRaw.addr1 = addressSelect1;
    pinRaw.clkLevel = linkClk;
  end

  // Two flip-flops on every carried pin before use; the link shifter and frameIdle take their pins raw
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // Reset state: power-on reset or synced external reset low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resetHold <= 1'b1;
    end else begin
      resetHold <= ~pinSync.extRstLow;
    end
  end

  assign inReset = resetHold;

  // Select level history for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      selectPrev <= 1'b0;
    end else if (resetHold) begin
      selectPrev <= 1'b0; // No edge taken across reset
    end else begin
      selectPrev <= pinSync.select;
    end
  end

  // Mode latch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= MODE_I2C;
    end else if (resetHold) begin
      mode <= MODE_I2C;
    end else begin
      case (mode)
        // Stay I2C while select stays high
        MODE_I2C: begin
          if (selectPrev && !pinSync.select) begin
            mode <= MODE_SPI;
          end
        end
        // Held whatever the select does
        MODE_SPI: begin
          mode <= MODE_SPI;
        end
        default: begin
          mode <= MODE_I2C;
        end
      endcase
    end
  end

  assign spiMode = (mode == MODE_SPI);

  // Data pin: open-drain in I2C, input only in SPI
  always_comb begin
    dataPinOut = 1'b0;
    dataPinOe = 1'b0;
    if (!resetHold && !spiMode) begin
      dataPinOe = i2cDataPullLow;
    end
  end

  // Address pin: address input in I2C, data out in SPI
  always_comb begin
    addressSelect0OrDataOutOut = 1'b0;
    addressSelect0OrDataOutOe = 1'b0;
    if (!resetHold && spiMode && !frameIdle) begin
      addressSelect0OrDataOutOut = linkSerialOut;
      addressSelect0OrDataOutOe = 1'b1;
    end
  end

  // Slave address sampled from synced address pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slaveAddress <= `SLAVE_ADDR_BASE;
    end else if (resetHold) begin
      slaveAddress <= `SLAVE_ADDR_BASE;
    end else if (!spiMode) begin
      slaveAddress <= addrOf(pinSync.addr1, pinSync.addr0);
    end
  end

  // Synced clock and data levels for the I2C engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      i2cClockLevel <= 1'b1;
      i2cDataLevel <= 1'b1;
    end else if (resetHold || spiMode) begin
      i2cClockLevel <= 1'b1; // Bus seen idle outside I2C
      i2cDataLevel <= 1'b1;
    end else begin
      i2cClockLevel <= pinSync.clkLevel;
      i2cDataLevel <= pinSync.dataLevel;
    end
  end

  // Sense pins: high impedance in reset, others low while measuring
  always_comb begin
    senseInputsOut = '0;
    senseInputsOe = '0;
    if (!resetHold && measureActive) begin
      senseInputsOe = '1;
      senseInputsOe[measureChannel] = 1'b0; // Selected one left to the amplifier
    end
    if (resetHold) begin
      senseInputsOe = '0;
    end
  end

  // Reference pins never driven, so high impedance in reset too
  always_comb begin
    refOut = 1'b0;
    refOe = 1'b0;
    extraReferenceInputOut = 1'b0;
    extraReferenceInputOe = 1'b0;
  end

  // Drive divider counts half periods while measuring
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      driveCount <= '0;
    end else if (resetHold || !measureActive) begin
      driveCount <= '0;
    end else if (driveCount == DRIVE_LAST) begin
      driveCount <= '0;
    end else begin
      driveCount <= driveCount + 1'b1;
    end
  end

  // Drive pulse toggles each half period, low when idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sensorDrive <= 1'b0;
    end else if (resetHold || !measureActive) begin
      sensorDrive <= 1'b0;
    end else if (driveCount == DRIVE_LAST) begin
      sensorDrive <= ~sensorDrive;
    end
  end

  // Measurement result capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resultValue <= '0;
      resultChannel <= '0;
    end else if (resetHold) begin
      resultValue <= '0;
      resultChannel <= '0;
    end else if (measureValid) begin
      resultValue <= measureValue;
      resultChannel <= measureChannel;
    end
  end

  // One-cycle pulse with each new result
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resultReady <= 1'b0;
    end else begin
      resultReady <= measureValid && !resetHold;
    end
  end

  // Interrupt line high through reset, falls on release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interruptLine <= `IRQ_RESET_LEVEL;
    end else if (resetHold) begin
      interruptLine <= `IRQ_RESET_LEVEL;
    end else begin
      interruptLine <= interruptRequest;
    end
  end

  // Chip select taken from the raw select pin in either mode; raw pin frames the link
  assign frameIdle = interfaceSelectStrobe;

  // Transmit byte only changes between frames
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txHold <= '0;
    end else if (resetHold) begin
      txHold <= '0;
    end else if (pinSync.select) begin
      txHold <= spiTxByte;
    end
  end

  // Link-clock side shifter, clocked by the shared clock pin
  spi_link_shifter linkShifter (
    .linkClk(linkClk),
    .rst(rst),
    .frameIdle(frameIdle),
    .serialIn(dataPinIn),
    .txByte(txHold),
    .serialOut(linkSerialOut),
    .rxByte(linkRxByte),
    .rxToggle(linkRxToggle)
  );

  // Byte event crosses as a toggle through two flip-flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      toggleMeta <= 1'b0;
      toggleSync <= 1'b0;
      toggleSeen <= 1'b0;
    end else begin
      toggleMeta <= linkRxToggle;
      toggleSync <= toggleMeta;
      toggleSeen <= toggleSync;
    end
  end

  // Received byte taken while stable, only in SPI mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spiRxByte <= '0;
      spiRxValid <= 1'b0;
    end else if (resetHold) begin
      spiRxByte <= '0;
      spiRxValid <= 1'b0;
    end else begin
      spiRxValid <= 1'b0;
      if (toggleSync != toggleSeen && spiMode) begin
        spiRxByte <= linkRxByte;
        spiRxValid <= 1'b1;
      end
    end
  end

endmodule

//--- rtl/spi_link_shifter.sv
`timescale 1ns/1ps
`include "hims_cfg.svh"

module spi_link_shifter import hims_pkg::*; (
  input wire logic linkClk,
  input wire logic rst,
  input wire logic frameIdle,
  input wire logic serialIn,
  input wire logic [`SPI_BITS-1:0] txByte,
  output logic serialOut,
  output logic [`SPI_BITS-1:0] rxByte,
  output logic rxToggle
);

  logic [2:0] bitCount; // Bits taken in this byte
  logic [2:0] outIndex; // Bit being presented
  logic [`SPI_BITS-2:0] shiftIn; // Partial byte

  // Sample on rising edge; cleared while chip select is high
  always_ff @(posedge linkClk or posedge frameIdle) begin
    if (frameIdle) begin
      bitCount <= 3'h0;
      shiftIn <= '0;
    end else begin
      bitCount <= bitCount + 3'h1;
      shiftIn <= {shiftIn[`SPI_BITS-3:0], serialIn};
    end
  end

  // Whole byte handed over with a toggle, kept across frames
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      rxByte <= '0;
      rxToggle <= 1'b0;
    end else if (!frameIdle && bitCount == 3'(`SPI_BITS - 1)) begin
      rxByte <= {shiftIn, serialIn};
      rxToggle <= ~rxToggle;
    end
  end

  // Shift out on falling edge, first bit ready at frame start
  always_ff @(negedge linkClk or posedge frameIdle) begin
    if (frameIdle) begin
      outIndex <= 3'h0;
    end else begin
      outIndex <= outIndex + 3'h1;
    end
  end

  // Most significant bit first
  assign serialOut = txByte[3'(`SPI_BITS - 1) - outIndex];

endmodule

//--- test/hims_chk_assertions.sv
`timescale 1ns/1ps

// Port checks for the mode select block
module hims_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inReset,
  input wire logic interruptLine,
  input wire logic interruptRequest,
  input wire logic spiMode,
  input wire logic interfaceSelectStrobe,
  input wire logic [15:0] senseInputsOe,
  input wire logic refOe,
  input wire logic extraReferenceInputOe,
  input wire logic dataPinOe,
  input wire logic i2cDataPullLow,
  input wire logic addressSelect0OrDataOutOe,
  input wire logic addressSelect0OrDataOutIn,
  input wire logic addressSelect1,
  input wire logic measureActive,
  input wire logic [3:0] measureChannel,
  input wire logic measureValid,
  input wire logic [7:0] measureValue,
  input wire logic resultReady,
  input wire logic [7:0] resultValue,
  input wire logic [3:0] resultChannel,
  input wire logic [6:0] slaveAddress
);
  // One clock domain, power-on reset disables all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_reset_hiz: assert property (inReset |-> senseInputsOe == 16'h0000 && !refOe && !extraReferenceInputOe)
    else $error("pins driven in reset");
  chk_sense_low: assert property (measureActive && !inReset |-> senseInputsOe == ~(16'h0001 << measureChannel))
    else $error("wrong channels driven low");
  chk_result_pair: assert property (measureValid && !inReset |=> resultReady && resultValue == $past(measureValue)
    && resultChannel == $past(measureChannel))
    else $error("result not delivered");
  chk_irq_follow: assert property (!inReset && !$past(inReset) |-> interruptLine == $past(interruptRequest))
    else $error("interrupt line wrong");
  chk_irq_release: assert property ($fell(inReset) && !interruptRequest |-> interruptLine ##1 !interruptLine)
    else $error("interrupt did not fall at release");
  chk_spi_latch: assert property (spiMode && !inReset |=> spiMode || inReset)
    else $error("spi mode lost");
  chk_mode_switch: assert property ($fell(interfaceSelectStrobe) && !inReset && !spiMode |-> ##[2:5] spiMode)
    else $error("no switch to spi");
  chk_slave_addr: assert property ((!spiMode && !inReset && $stable({addressSelect1, addressSelect0OrDataOutIn})) [*5]
    |-> slaveAddress == 7'h16 + {5'h00, addressSelect1, addressSelect0OrDataOutIn})
    else $error("slave address wrong");
  chk_pin_roles: assert property (!inReset |-> addressSelect0OrDataOutOe == (spiMode && !interfaceSelectStrobe)
    && dataPinOe == (!spiMode && i2cDataPullLow))
    else $error("shared pin role wrong");
endmodule

bind host_interface_mode_select hims_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .inReset(inReset), .interruptLine(interruptLine),
  .interruptRequest(interruptRequest), .spiMode(spiMode), .interfaceSelectStrobe(interfaceSelectStrobe),
  .senseInputsOe(senseInputsOe), .refOe(refOe), .extraReferenceInputOe(extraReferenceInputOe),
  .dataPinOe(dataPinOe), .i2cDataPullLow(i2cDataPullLow), .addressSelect0OrDataOutOe(addressSelect0OrDataOutOe),
  .addressSelect0OrDataOutIn(addressSelect0OrDataOutIn), .addressSelect1(addressSelect1),
  .measureActive(measureActive), .measureChannel(measureChannel), .measureValid(measureValid),
  .measureValue(measureValue), .resultReady(resultReady), .resultValue(resultValue),
  .resultChannel(resultChannel), .slaveAddress(slaveAddress)
);

//--- test/host_spi_model.sv
`timescale 1ns/1ps

// Host side: mode 0 master, select high keeps I2C
module host_spi_model (
  output logic linkClk,
  output logic selectLow,
  output logic mosi,
  input wire logic miso
);
  // Idle: clock still low, select held high
  initial begin
    linkClk = 1'h0;
    selectLow = 1'h1;
    mosi = 1'h1;
  end
  // Select fall with no clocks, picks SPI
  task automatic selectPulse();
    selectLow = 1'h0;
    #500 selectLow = 1'h1;
  endtask
  // One byte, MSB first, sampled on rising clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    selectLow = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #62.5 linkClk = 1'h1;
      rx[i] = miso;
      #62.5 linkClk = 1'h0;
    end
    #62.5 selectLow = 1'h1;
    mosi = ~mosi; // Released line must not look held
  endtask
endmodule

//--- test/test_host_interface_mode_select.sv
`timescale 1ns/1ps

module test_host_interface_mode_select import hims_pkg::*; ;
  // Bench-driven inputs, changed at falling edge
  logic sys_clk = 1'h0, rst = 1'h1, externalResetLow = 1'h1, i2cDataPullLow = 1'h0;
  logic measureActive = 1'h0, measureValid = 1'h0, interruptRequest = 1'h0, addressSelect1 = 1'h0, addr0Level = 1'h0;
  logic [3:0] measureChannel = 4'h0;
  logic [7:0] measureValue = 8'h00, spiTxByte = 8'h00, rx;
  // Resolved pins
  wire linkClk, interfaceSelectStrobe, hostData, dataPinIn, addressSelect0OrDataOutIn;
  // Design outputs
  logic dataPinOut, dataPinOe, addressSelect0OrDataOutOut, addressSelect0OrDataOutOe, refOut, refOe;
  logic extraReferenceInputOut, extraReferenceInputOe, sensorDrive, interruptLine, spiMode, inReset;
  logic i2cClockLevel, i2cDataLevel, resultReady, spiRxValid;
  logic [15:0] senseInputsOut, senseInputsOe;
  logic [6:0] slaveAddress;
  logic [7:0] resultValue, spiRxByte;
  logic [3:0] resultChannel;
  int failCount = 0, testsRun = 0, rxCount = 0, n;
  // Measurement rows: channel, value, interrupt, expected drive-low mask
  typedef struct packed { logic [3:0] ch; logic [7:0] val; logic irq; logic [15:0] oe; } row_t;
  row_t rows [4] = '{'{4'h0, 8'h00, 1'h1, 16'hFFFE}, '{4'hF, 8'hFF, 1'h0, 16'h7FFF},
                     '{4'h7, 8'h5A, 1'h1, 16'hFF7F}, '{4'h9, 8'hA5, 1'h0, 16'hFDFF}};

  // Open-drain data pin, address pin strap or serial out
  assign dataPinIn = dataPinOe ? dataPinOut : hostData;
  assign addressSelect0OrDataOutIn = addressSelect0OrDataOutOe ? addressSelect0OrDataOutOut : addr0Level;

  host_interface_mode_select u_dut (
    .sys_clk(sys_clk), .rst(rst), .linkClk(linkClk), .externalResetLow(externalResetLow),
    .interfaceSelectStrobe(interfaceSelectStrobe), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
    .dataPinOe(dataPinOe), .addressSelect0OrDataOutIn(addressSelect0OrDataOutIn),
    .addressSelect0OrDataOutOut(addressSelect0OrDataOutOut), .addressSelect0OrDataOutOe(addressSelect0OrDataOutOe),
    .addressSelect1(addressSelect1), .senseInputsOut(senseInputsOut), .senseInputsOe(senseInputsOe),
    .refOut(refOut), .refOe(refOe), .extraReferenceInputOut(extraReferenceInputOut),
    .extraReferenceInputOe(extraReferenceInputOe), .sensorDrive(sensorDrive), .interruptLine(interruptLine),
    .i2cDataPullLow(i2cDataPullLow), .measureActive(measureActive), .measureChannel(measureChannel),
    .measureValid(measureValid), .measureValue(measureValue), .interruptRequest(interruptRequest),
    .spiTxByte(spiTxByte), .spiMode(spiMode), .inReset(inReset), .slaveAddress(slaveAddress),
    .i2cClockLevel(i2cClockLevel), .i2cDataLevel(i2cDataLevel), .resultValue(resultValue),
    .resultChannel(resultChannel), .resultReady(resultReady), .spiRxByte(spiRxByte), .spiRxValid(spiRxValid)
  );
  host_spi_model u_host (.linkClk(linkClk), .selectLow(interfaceSelectStrobe), .mosi(hostData),
    .miso(addressSelect0OrDataOutIn));

  // System clock and received byte counter
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    if (spiRxValid === 1'h1) begin
      rxCount++;
    end
  end

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (failCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #500000;
    failCount++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    check("irq", interruptLine, 1'h1);
    check("inReset", inReset, 1'h1);
    check("senseOe", senseInputsOe, 16'h0000);
    check("mode", spiMode, 1'h0);
    rst = 1'h0;
    repeat (6) @(negedge sys_clk);
    check("irq", interruptLine, 1'h0);
    check("inReset", inReset, 1'h0);
    // All four strap settings
    for (int a = 0; a < 4; a++) begin
      {addressSelect1, addr0Level} = a[1:0];
      repeat (5) @(negedge sys_clk);
      check("addr", {9'h000, slaveAddress}, 16'h0016 + 16'(a));
    end
    addressSelect1 = 1'h0;
    addr0Level = 1'h0;
    measureActive = 1'h1;
    foreach (rows[i]) begin
      measureChannel = rows[i].ch;
      measureValue = rows[i].val;
      interruptRequest = rows[i].irq;
      measureValid = 1'h1;
      @(negedge sys_clk);
      check("value", resultValue, rows[i].val);
      check("channel", resultChannel, rows[i].ch);
      check("ready", resultReady, 1'h1);
      check("senseOe", senseInputsOe, rows[i].oe);
      check("senseOut", senseInputsOut, 16'h0000);
      check("irq", interruptLine, rows[i].irq);
    end
    measureValid = 1'h0;
    @(negedge sys_clk);
    check("ready", resultReady, 1'h0);
    // Drive pulse half period
    n = 0;
    while (sensorDrive !== 1'h1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (sensorDrive === 1'h1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check("driveHalf", 16'(n), 16'h0045);
    // Open-drain data in I2C mode
    i2cDataPullLow = 1'h1;
    repeat (4) @(negedge sys_clk);
    check("dataOe", dataPinOe, 1'h1);
    check("dataLevel", i2cDataLevel, 1'h0);
    check("clkLevel", i2cClockLevel, 1'h0);
    check("quietPins", {refOut, refOe, extraReferenceInputOut, extraReferenceInputOe, dataPinOut}, 5'h00);
    // Switch to SPI, then one byte each way
    spiTxByte = 8'hA5;
    u_host.selectPulse();
    repeat (10) @(negedge sys_clk);
    check("mode", spiMode, 1'h1);
    check("dataOe", dataPinOe, 1'h0);
    check("i2cLevels", {i2cClockLevel, i2cDataLevel}, 2'h3);
    u_host.xfer(8'h3C, rx);
    repeat (6) @(negedge sys_clk);
    check("serialOut", rx, 8'hA5);
    check("serialIn", spiRxByte, 8'h3C);
    check("rxCount", 16'(rxCount), 16'h0001);
    check("mode", spiMode, 1'h1);
    // External reset in mid-run clears the mode
    externalResetLow = 1'h0;
    repeat (6) @(negedge sys_clk);
    check("inReset", inReset, 1'h1);
    check("senseOe", senseInputsOe, 16'h0000);
    externalResetLow = 1'h1;
    repeat (8) @(negedge sys_clk);
    check("mode", spiMode, 1'h0);
    check("inReset", inReset, 1'h0);
    // Power-on reset in mid-run also clears the mode
    u_host.selectPulse();
    repeat (10) @(negedge sys_clk);
    check("mode", spiMode, 1'h1);
    rst = 1'h1;
    @(negedge sys_clk);
    check("mode", spiMode, 1'h0);
    check("irq", interruptLine, 1'h1);
    rst = 1'h0;
    repeat (6) @(negedge sys_clk);
    check("inReset", inReset, 1'h0);
    check("irq", interruptLine, 1'h0);
    check("mode", spiMode, 1'h0);
    summarize();
  end
endmodule
